// ===== design/nvm_ctrl_defines.vh
// register map, field positions, reset values and timing counts
// assumes: included by the data eeprom control logic, 10 MHz clock
`ifndef NVM_CTRL_DEFINES_VH
`define NVM_CTRL_DEFINES_VH
`define REG_LOC_SEL 2'h0
`define REG_BYTE_HOLD 2'h1
`define REG_UNLOCK_KEY 2'h2
`define REG_ACC_CTRL 2'h3
`define BIT_MEM_SPACE 7
`define BIT_CFG_SPACE 6
`define BIT_ERASE_ROW 4
`define BIT_ABORT 3
`define BIT_PERMIT 2
`define BIT_COMMIT 1
`define BIT_FETCH 0
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa
`define CTRL_RESET 8'h00
`define CLK_PERIOD_NS 100
`define WRITE_TIME_US 4000
`define WRITE_CYCLES ((`WRITE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define PWRT_TIME_US 65600
`define PWRT_CYCLES ((`PWRT_TIME_US * 1000) / `CLK_PERIOD_NS)
`endif

// ===== design/nvm_byte_array.v
// 256 x 8 byte array standing in for the eeprom cells
// assumes: one port, registered read data, single clock
`timescale 1ns/1ns
module nvm_byte_array (
  input wire mclk_in,
  input wire wr_en_in,
  input wire [7:0] addr_in,
  input wire [7:0] wr_data_in,
  output reg [7:0] rd_data_out
);
  reg [7:0] cells [0:255];
  always @(posedge mclk_in) begin
    if (wr_en_in) begin
      cells[addr_in] <= wr_data_in;
    end
    rd_data_out <= cells[addr_in];
  end
endmodule // nvm_byte_array

// ===== design/nvm_write_ctrl.v
// data eeprom read and self-timed write control behind four registers
// assumes: cpu register port on mclk_in, external port and protect strap from pins
// Summary of operation
// - key 55h then aah then commit
// - commit refused unless permit already set
// - neither commit nor permit can be changed while a write runs
// - hardware never clears the permit bit
// - registers locked while a write runs
// - completion clears commit, sets done flag
// - done flag sticky until software clears it
// - code protect blocks external array access
// - cpu access ignores code protect
// - permit bit cleared at power up
// - writes blocked during power-up timer
// - fetch loads data next cycle, self-clears
// - fetch refused with either space select set
// - 8-bit address selects 256 bytes
// - key register reads as zero
`timescale 1ns/1ns
`include "nvm_ctrl_defines.vh"
module nvm_write_ctrl #(
  parameter WRITE_CYCLES = `WRITE_CYCLES,
  parameter PWRT_CYCLES = `PWRT_CYCLES
) (
  input wire mclk_in,
  input wire nrst_in,
  input wire [1:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  input wire done_clear_in,
  output reg cycle_done_flag_out,
  input wire code_protect_in,
  input wire ext_req_in,
  input wire ext_wr_in,
  input wire [7:0] ext_addr_in,
  input wire [7:0] ext_wdata_in,
  output reg [7:0] ext_rdata_out,
  output reg ext_refused_out,
  output reg busy_out
);
  localparam ST_IDLE = 2'd0;
  localparam ST_KEY1 = 2'd1;
  localparam ST_KEY2 = 2'd2;

  reg [7:0] loc_q;
  reg [7:0] data_q;
  reg mem_space_q;
  reg cfg_space_q;
  reg erase_row_q;
  reg abort_q;
  reg permit_q;
  reg commit_q;
  reg fetch_q;
  reg [1:0] key_q;
  reg [22:0] wtimer_q;
  reg [22:0] ptimer_q;
  reg pwrt_done_q;
  reg cp_meta_q;
  reg cp_sync_q;
  reg req_meta_q;
  reg req_sync_q;
  reg req_last_q;
  reg wr_meta_q;
  reg wr_sync_q;
  reg ext_pend_q;
  reg ext_pend_wr_q;
  reg ext_rd_q;
  reg [7:0] rdata_d;
  wire [15:0] pin_bus;
  wire [15:0] pin_sync;
  wire [7:0] ea_sync;
  wire [7:0] ed_sync;
  wire key_first_wr;
  wire key_second_wr;
  wire reg_access;
  wire ext_serve;
  wire [7:0] arr_rdata;
  wire [7:0] ctrl_view;
  wire ext_start;
  wire wr_ctrl;
  wire cpu_write_go;
  wire arr_we;
  wire [7:0] arr_addr;
  wire [7:0] arr_wdata;
  wire write_end;

  assign ctrl_view = {mem_space_q,
                      cfg_space_q,
                      1'b0,
                      erase_row_q,
                      abort_q,
                      permit_q,
                      commit_q,
                      fetch_q};
  assign wr_ctrl = reg_wr_in && (reg_addr_in == `REG_ACC_CTRL);
  assign key_first_wr = reg_wr_in && (reg_addr_in == `REG_UNLOCK_KEY) &&
                        (reg_wdata_in == `KEY_FIRST);
  assign key_second_wr = reg_wr_in && (reg_addr_in == `REG_UNLOCK_KEY) &&
                         (reg_wdata_in == `KEY_SECOND);
  assign reg_access = reg_wr_in || reg_rd_in;
  // commit accepted only after full key, prior permit, timer expired
  assign cpu_write_go = wr_ctrl && !commit_q && reg_wdata_in[`BIT_COMMIT] &&
                        (key_q == ST_KEY2) && permit_q &&
                        pwrt_done_q;
  assign write_end = commit_q && (wtimer_q == 23'd1);
  assign ext_start = req_sync_q && !req_last_q;
  assign pin_bus = {ext_wdata_in, ext_addr_in};
  assign ea_sync = pin_sync[7:0];
  assign ed_sync = pin_sync[15:8];
  // external port shares the array; only a running cpu write cycle holds it off
  assign ext_serve = ext_pend_q && !commit_q;
  assign arr_we = write_end || (ext_serve && ext_pend_wr_q && pwrt_done_q);
  assign arr_addr = (commit_q || !ext_pend_q) ? loc_q : ea_sync;
  assign arr_wdata = (commit_q || !ext_pend_q) ? data_q : ed_sync;

  nvm_byte_array u_array (
    .mclk_in(mclk_in),
    .wr_en_in(arr_we),
    .addr_in(arr_addr),
    .wr_data_in(arr_wdata),
    .rd_data_out(arr_rdata)
  );

  // one flop pair per address and data bit; the pins are held steady
  // before the request edge, so no bit is taken while it still moves
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_pin_sync
      reg meta_q;
      reg sync_q;
      always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= pin_bus[gi];
          sync_q <= meta_q;
        end
      end
      assign pin_sync[gi] = sync_q;
    end
  endgenerate

  // pin inputs pass two flops before use
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cp_meta_q <= 1'b0;
      cp_sync_q <= 1'b0;
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
      req_last_q <= 1'b0;
      wr_meta_q <= 1'b0;
      wr_sync_q <= 1'b0;
    end else begin
      cp_meta_q <= code_protect_in;
      cp_sync_q <= cp_meta_q;
      req_meta_q <= ext_req_in;
      req_sync_q <= req_meta_q;
      req_last_q <= req_sync_q;
      wr_meta_q <= ext_wr_in;
      wr_sync_q <= wr_meta_q;
    end
  end

  // power-up timer; nrst_in is the power-on reset
  // any reset restarts it, so a glitch also re-arms the write block
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ptimer_q <= 23'd0;
      pwrt_done_q <= 1'b0;
    end else if (!pwrt_done_q) begin
      ptimer_q <= ptimer_q + 23'd1;
      if (ptimer_q == PWRT_CYCLES[22:0] - 23'd1) begin
        pwrt_done_q <= 1'b1;
      end
    end
  end

  // unlock sequencer: any other register access drops progress
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      key_q <= ST_IDLE;
    end else if (reg_access) begin
      case (key_q)
        ST_IDLE: begin
          if (key_first_wr) begin
            key_q <= ST_KEY1;
          end
        end
        ST_KEY1: begin
          if (key_second_wr) begin
            key_q <= ST_KEY2;
          end else begin
            key_q <= ST_IDLE;
          end
        end
        ST_KEY2: begin
          key_q <= ST_IDLE;
        end
        default: begin
          key_q <= ST_IDLE;
        end
      endcase
    end
  end

  // control, address and data registers
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      loc_q <= 8'h00;
      data_q <= 8'h00;
      mem_space_q <= 1'b0;
      cfg_space_q <= 1'b0;
      erase_row_q <= 1'b0;
      abort_q <= 1'b0;
      permit_q <= 1'b0;
      commit_q <= 1'b0;
      fetch_q <= 1'b0;
      wtimer_q <= 23'd0;
    end else begin
      fetch_q <= 1'b0;
      if (fetch_q) begin
        data_q <= arr_rdata;
      end
      if (commit_q) begin
        // locked until the cycle ends
        wtimer_q <= wtimer_q - 23'd1;
        if (write_end) begin
          commit_q <= 1'b0;
          abort_q <= 1'b0;
          erase_row_q <= 1'b0;
        end
      end else if (reg_wr_in) begin
        case (reg_addr_in)
          `REG_LOC_SEL: begin
            loc_q <= reg_wdata_in;
          end
          `REG_BYTE_HOLD: begin
            data_q <= reg_wdata_in;
          end
          `REG_ACC_CTRL: begin
            mem_space_q <= reg_wdata_in[`BIT_MEM_SPACE];
            cfg_space_q <= reg_wdata_in[`BIT_CFG_SPACE];
            erase_row_q <= reg_wdata_in[`BIT_ERASE_ROW];
            // permit is only ever changed by firmware
            permit_q <= reg_wdata_in[`BIT_PERMIT];
            if (cpu_write_go) begin
              commit_q <= 1'b1;
              abort_q <= 1'b1;
              wtimer_q <= WRITE_CYCLES[22:0];
            end else begin
              abort_q <= reg_wdata_in[`BIT_ABORT];
            end
            if (reg_wdata_in[`BIT_FETCH] && !reg_wdata_in[`BIT_MEM_SPACE] &&
                !reg_wdata_in[`BIT_CFG_SPACE] && !mem_space_q && !cfg_space_q) begin
              fetch_q <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // done flag: set beats clear
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cycle_done_flag_out <= 1'b0;
    end else if (write_end) begin
      cycle_done_flag_out <= 1'b1;
    end else if (done_clear_in) begin
      cycle_done_flag_out <= 1'b0;
    end
  end

  // external access port, one request per rising edge of ext_req_in
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_pend_q <= 1'b0;
      ext_pend_wr_q <= 1'b0;
      ext_rdata_out <= 8'h00;
      ext_refused_out <= 1'b0;
      ext_rd_q <= 1'b0;
    end else begin
      ext_rd_q <= 1'b0;
      if (ext_start) begin
        if (cp_sync_q) begin
          ext_refused_out <= 1'b1;
        end else begin
          ext_refused_out <= 1'b0;
          ext_pend_q <= 1'b1;
          ext_pend_wr_q <= wr_sync_q;
        end
      end else if (ext_serve) begin
        // the array registers its read data, so the byte is taken one edge later
        ext_pend_q <= 1'b0;
        ext_pend_wr_q <= 1'b0;
        ext_rd_q <= !ext_pend_wr_q;
      end
      if (ext_rd_q) begin
        ext_rdata_out <= arr_rdata;
      end
    end
  end

  // read mux; the key register is write-only and holds nothing to return
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr_in)
      `REG_LOC_SEL: begin
        rdata_d = loc_q;
      end
      `REG_BYTE_HOLD: begin
        rdata_d = data_q;
      end
      `REG_UNLOCK_KEY: begin
        rdata_d = 8'h00;
      end
      `REG_ACC_CTRL: begin
        rdata_d = ctrl_view;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // register read port, data in the cycle after the strobe
  // zero outside a read so a stale byte never looks like an answer
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 8'h00;
      busy_out <= 1'b0;
    end else begin
      busy_out <= commit_q;
      reg_rdata_out <= reg_rd_in ? rdata_d : 8'h00;
    end
  end
endmodule // nvm_write_ctrl

// ===== dv/nvm_write_ctrl_props.sv
// port checker for the data eeprom write control
// assumes: bound to nvm_write_ctrl, one clock, async active-low reset
`timescale 1ns/1ns
module nvm_write_ctrl_props #(
  parameter WRITE_CYCLES = 20,
  parameter PWRT_CYCLES = 30
) (
  input wire mclk_in,
  input wire nrst_in,
  input wire [1:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire done_clear_in,
  input wire cycle_done_flag_out,
  input wire busy_out
);
  reg [31:0] bcnt_q;
  reg [31:0] pcnt_q;
  reg seen55_q;
  reg seen_aa_q;
  // counters stand in for long repetitions, which the tools unroll badly
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bcnt_q <= 32'h0;
      pcnt_q <= 32'h0;
      seen55_q <= 1'b0;
      seen_aa_q <= 1'b0;
    end else begin
      bcnt_q <= busy_out ? bcnt_q + 32'h1 : 32'h0;
      if (pcnt_q < PWRT_CYCLES) pcnt_q <= pcnt_q + 32'h1;
      // shadow of the key: independent of how far apart the bus accesses are
      if (reg_wr_in || reg_rd_in) begin
        seen55_q <= reg_wr_in && reg_addr_in == 2'h2 && reg_wdata_in == 8'h55;
        seen_aa_q <= seen55_q && reg_wr_in && reg_addr_in == 2'h2 && reg_wdata_in == 8'haa;
      end
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  key_read_zero_a: assert property (
    reg_rd_in && reg_addr_in == 2'h2 |=> reg_rdata_out == 8'h00)
    else $error("key register read not zero");
  done_sticky_a: assert property (
    cycle_done_flag_out && !done_clear_in |=> cycle_done_flag_out)
    else $error("done flag dropped without clear");
  done_at_end_a: assert property (
    $rose(cycle_done_flag_out) |-> ##1 !busy_out)
    else $error("done flag raised while write still running");
  write_len_a: assert property (
    $fell(busy_out) |-> bcnt_q >= WRITE_CYCLES - 1 && bcnt_q <= WRITE_CYCLES + 1)
    else $error("write cycle length wrong");
  pwrt_block_a: assert property (
    busy_out |-> pcnt_q >= PWRT_CYCLES)
    else $error("write started inside power-up interval");
  start_key_a: assert property (
    $rose(busy_out) |-> $past(seen_aa_q, 2) && $past(reg_wr_in, 2) &&
    $past(reg_addr_in, 2) == 2'h3)
    else $error("write started without key sequence");
  busy_shows_a: assert property (
    reg_rd_in && reg_addr_in == 2'h3 ##1 busy_out |-> reg_rdata_out[1])
    else $error("commit bit low while busy");
  rd_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside read cycle");
endmodule // nvm_write_ctrl_props
bind nvm_write_ctrl nvm_write_ctrl_props #(
  .WRITE_CYCLES(WRITE_CYCLES), .PWRT_CYCLES(PWRT_CYCLES)
) chk_u (
  .mclk_in(mclk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .done_clear_in(done_clear_in), .cycle_done_flag_out(cycle_done_flag_out), .busy_out(busy_out));

// ===== dv/nvm_write_ctrl_tb.sv
// register-level tests of the data eeprom write control
// assumes: shortened write and power-up counts, bench drives every port
`timescale 1ns/1ns
module nvm_write_ctrl_tb;
  reg mclk_in = 1'b0, nrst_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, done_clear_in = 1'b0;
  reg code_protect_in = 1'b1, ext_req_in = 1'b0, ext_wr_in = 1'b0;
  reg [1:0] reg_addr_in = 2'h0;
  reg [7:0] reg_wdata_in = 8'h00, ext_addr_in = 8'h00, ext_wdata_in = 8'h00, r;
  wire [7:0] reg_rdata_out, ext_rdata_out;
  wire cycle_done_flag_out, ext_refused_out, busy_out;
  integer n_fail = 0, n_tests = 0, cyc = 0, i;
  nvm_write_ctrl #(.WRITE_CYCLES(20), .PWRT_CYCLES(30)) dut_u (.mclk_in(mclk_in),
    .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .done_clear_in(done_clear_in), .cycle_done_flag_out(cycle_done_flag_out),
    .code_protect_in(code_protect_in), .ext_req_in(ext_req_in), .ext_wr_in(ext_wr_in),
    .ext_addr_in(ext_addr_in), .ext_wdata_in(ext_wdata_in), .ext_rdata_out(ext_rdata_out),
    .ext_refused_out(ext_refused_out), .busy_out(busy_out));
  initial begin
    forever #50 mclk_in = ~mclk_in;
  end
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge mclk_in) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      give_verdict;
    end
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [1:0] a, input [7:0] d);
    begin
      @(posedge mclk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge mclk_in);
      reg_wr_in <= 1'b0;
    end
  endtask
  task rd(input [1:0] a);
    begin
      @(posedge mclk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge mclk_in);
      reg_rd_in <= 1'b0;
      #1 r = reg_rdata_out;
    end
  endtask
  task unlock(input [7:0] c);
    begin
      wr(2'h2, 8'h55);
      wr(2'h2, 8'haa);
      wr(2'h3, c);
    end
  endtask
  task ext_acc(input w, input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk_in);
      ext_wr_in <= w;
      ext_addr_in <= a;
      ext_wdata_in <= d;
      repeat (3) @(posedge mclk_in);
      ext_req_in <= 1'b1;
      repeat (8) @(posedge mclk_in);
      ext_req_in <= 1'b0;
      repeat (8) @(posedge mclk_in);
    end
  endtask
  initial begin
    repeat (5) @(posedge mclk_in);
    nrst_in <= 1'b1;
    rd(2'h3);
    chk(r, 8'h00);
    rd(2'h2);
    chk(r, 8'h00);
    wr(2'h0, 8'h05);
    wr(2'h1, 8'h3c);
    wr(2'h3, 8'h04);
    unlock(8'h06);
    rd(2'h3);
    chk(r & 8'h07, 8'h04);
    $display("test powerup done");
    repeat (30) @(posedge mclk_in);
    wr(2'h3, 8'h00);
    unlock(8'h06);
    rd(2'h3);
    chk(r & 8'h02, 8'h00);
    wr(2'h2, 8'h55);
    rd(2'h0);
    wr(2'h2, 8'haa);
    wr(2'h3, 8'h06);
    rd(2'h3);
    chk(r & 8'h06, 8'h04);
    $display("test refusals done");
    // protect stays high here: cpu writes must ignore it
    unlock(8'h06);
    rd(2'h3);
    chk(r & 8'h06, 8'h06);
    chk({7'h0, busy_out}, 8'h01);
    wr(2'h0, 8'h09);
    wr(2'h1, 8'h11);
    wr(2'h3, 8'h00);
    rd(2'h0);
    chk(r, 8'h05);
    rd(2'h1);
    chk(r, 8'h3c);
    rd(2'h3);
    chk(r & 8'h06, 8'h06);
    for (i = 0; i < 100 && cycle_done_flag_out !== 1'b1; i = i + 1) @(posedge mclk_in);
    chk({7'h0, cycle_done_flag_out}, 8'h01);
    rd(2'h3);
    chk(r & 8'h06, 8'h04);
    repeat (5) @(posedge mclk_in);
    chk({7'h0, cycle_done_flag_out}, 8'h01);
    done_clear_in <= 1'b1;
    @(posedge mclk_in);
    done_clear_in <= 1'b0;
    @(posedge mclk_in);
    chk({7'h0, cycle_done_flag_out}, 8'h00);
    wr(2'h3, 8'h00);
    rd(2'h3);
    chk(r & 8'h04, 8'h00);
    $display("test write done");
    wr(2'h1, 8'h00);
    wr(2'h3, 8'h05);
    rd(2'h1);
    chk(r, 8'h3c);
    rd(2'h3);
    chk(r & 8'h01, 8'h00);
    for (i = 0; i < 2; i = i + 1) begin
      wr(2'h1, 8'h00);
      wr(2'h3, i ? 8'h45 : 8'h85);
      rd(2'h1);
      chk(r, 8'h00);
    end
    wr(2'h3, 8'h00);
    $display("test fetch done");
    ext_acc(1'b1, 8'h05, 8'hff);
    chk({7'h0, ext_refused_out}, 8'h01);
    code_protect_in <= 1'b0;
    ext_acc(1'b0, 8'h05, 8'h00);
    chk({7'h0, ext_refused_out}, 8'h00);
    chk(ext_rdata_out, 8'h3c);
    ext_acc(1'b1, 8'h22, 8'h5a);
    ext_acc(1'b0, 8'h22, 8'h00);
    chk(ext_rdata_out, 8'h5a);
    $display("test external done");
    give_verdict;
  end
endmodule // nvm_write_ctrl_tb
